// ==== rtl/svd_consts.vh ====
// constants for the supply voltage detector control block
// assumes inclusion by every design file of the block, by bare name
`ifndef SVD_CONSTS_VH
`define SVD_CONSTS_VH

// configuration address of the non-volatile option byte holding mode and level
`define SVD_OPT_ADDR         20'h000C1

// option byte layout
`define SVD_OPT_MODE_LO      0
`define SVD_OPT_MODE_HI      1
`define SVD_OPT_LVL_LSB      2
`define SVD_OPT_LVL_MSB      5

// mode field codes {undervolt_mode_sel_hi, undervolt_mode_sel_lo}
`define SVD_MODE_OFF         2'h0
`define SVD_MODE_IRQ         2'h1
`define SVD_MODE_IRQRST      2'h2
`define SVD_MODE_RST         2'h3

// eleven selectable levels, codes 0 .. 10
`define SVD_LVL_MAX          4'hA
`define SVD_LVL_W            4

// register offsets
`define SVD_REG_CTRL         8'h00
`define SVD_REG_LEVEL        8'h01
`define SVD_REG_CAUSE        8'h02
`define SVD_REG_OPT          8'h03
`define SVD_REG_STAT         8'h04

// field positions
`define SVD_CTRL_FLAG_BIT    0
`define SVD_CTRL_RESET_BIT   1
`define SVD_CTRL_EN_BIT      7
`define SVD_LEVEL_SEL_BIT    0
`define SVD_LEVEL_MODE_BIT   7
`define SVD_CAUSE_BIT        0
`define SVD_STAT_HI_BIT      0
`define SVD_STAT_LO_BIT      1
`define SVD_STAT_EDGE_LSB    4
`define SVD_STAT_EDGE_MSB    7

// reset values
`define SVD_LEVEL_RST        1'h0
`define SVD_OPT_RST          8'h00
`define SVD_RDATA_ZERO       8'h00
`define SVD_EDGE_RST         4'h0
`define SVD_EDGE_ONE         4'h1

// synchroniser depth
`define SVD_SYNC_STAGES      2

// comparator outputs crossing into clk: high level and low level
`define SVD_CMP_COUNT        2

`endif

// ==== rtl/svd_sync.v ====
// two-flop level synchroniser for the asynchronous comparator outputs
// assumes inputs change slowly compared with clk; reset is synchronous
`default_nettype none
`include "svd_consts.vh"

module svd_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // reset to all low: reads as below threshold, the safe side
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ==== rtl/svd_ctrl.v ====
// control logic around the supply under-voltage detector comparators
// assumes comparator outputs are asynchronous and the option byte is loaded
// by the non-volatile loader after rst, marked by a one-cycle opt_valid
//
// What this block does
// RQ1: mode and level come from the option byte at the fixed configuration address, never from software writes.
// RQ2: the detection level is one of eleven codes taken from the option byte.
// RQ3: the synchronised supply comparison against the chosen level drives a reset or an interrupt as the mode says.
// RQ4: detection, reset and interrupt keep working in stop, since nothing here is gated by the low-power state.
// RQ5: in mode 1,0 an interrupt fires when supply falls below the high level, reset below the low level, release at high.
// RQ6: in mode 1,1 reset follows the single level directly and no interrupt is raised.
// RQ7: in mode 0,1 reset is held from reset generation until supply is first seen at or above the level.
// RQ8: in mode 0,1 after that release, every crossing of the level in either direction raises the interrupt.
// RQ9: bit 0 of the control register shows whether the supply is below the detection level.
// RQ10: a reset caused by the detector sets bit 0 of the reset-cause register.
// RQ11: the system keeps the chip in reset until the supply is in range, and stops or resets it before it leaves.
// RQ12: when the interrupt fires, both the level-select and mode bits of the level register become 1.
// RQ13: comparator outputs pass two flip-flops before any logic looks at them.
`default_nettype none
`include "svd_consts.vh"

module svd_ctrl (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  cmp_hi_ok,
  input  wire                  cmp_lo_ok,
  input  wire [7:0]            opt_byte,
  input  wire                  opt_valid,
  output wire [19:0]           opt_addr,
  input  wire [7:0]            reg_addr,
  input  wire [7:0]            reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output wire [7:0]            reg_rdata,
  output wire                  undervolt_reset,
  output wire                  undervolt_irq,
  output wire                  supply_level_flag,
  output wire [`SVD_LVL_W-1:0] threshold_sel,
  output wire [1:0]            detector_mode,
  output wire                  detector_enable
);

  // one-hot states
  localparam [3:0] ST_LOAD = 4'h1;
  localparam [3:0] ST_HOLD = 4'h2;
  localparam [3:0] ST_RUN  = 4'h4;
  localparam [3:0] ST_OFF  = 4'h8;

  // codes above the last level fall back to the last one
  function [`SVD_LVL_W-1:0] f_clamp_level;
    input [`SVD_LVL_W-1:0] code;
    begin
      if (code > `SVD_LVL_MAX) begin
        f_clamp_level = `SVD_LVL_MAX;
      end else begin
        f_clamp_level = code;
      end
    end
  endfunction

  function [1:0] f_mode;
    input [7:0] ob;
    begin
      f_mode = {ob[`SVD_OPT_MODE_HI], ob[`SVD_OPT_MODE_LO]};
    end
  endfunction

  function f_hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      f_hit = (addr == offs);
    end
  endfunction

  reg  [3:0]            state_q;
  reg  [3:0]            state_d;
  reg  [7:0]            opt_q;
  reg  [7:0]            opt_d;
  reg                   rst_q;
  reg                   rst_d;
  reg                   irq_q;
  reg                   irq_d;
  reg                   hi_prev_q;
  reg                   flag_q;
  reg                   flag_d;
  reg                   lvl_sel_q;
  reg                   lvl_sel_d;
  reg                   rsi_sel_q;
  reg                   rsi_sel_d;
  reg                   cause_q;
  reg                   cause_d;
  reg  [3:0]            edge_cnt_q;
  reg  [3:0]            edge_cnt_d;
  reg  [7:0]            rdata_q;
  reg  [7:0]            rdata_d;
  wire [1:0]            cmp_sync;
  wire                  hi_ok_s;
  wire                  lo_ok_s;
  wire [1:0]            mode;
  wire [`SVD_LVL_W-1:0] level;
  wire                  hi_fall;
  wire                  hi_cross;
  wire                  in_run;
  wire                  det_en;
  wire [1:0]            load_mode;
  wire                  two_level;
  wire                  wr_level;
  wire                  wr_stat;
  wire                  rd_cause;
  wire                  det_reset_rise;

  // comparators are analog and free running, so they are synchronised first
  svd_sync #(
    .WIDTH(`SVD_CMP_COUNT)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({cmp_lo_ok, cmp_hi_ok}),
    .sync_out (cmp_sync)
  ); // [RQ13]

  assign hi_ok_s  = cmp_sync[0];
  assign lo_ok_s  = cmp_sync[1];
  assign mode     = f_mode(opt_q);
  assign level    = f_clamp_level(opt_q[`SVD_OPT_LVL_MSB:`SVD_OPT_LVL_LSB]); // [RQ2]
  assign hi_fall  = hi_prev_q & ~hi_ok_s;
  assign hi_cross = hi_prev_q ^ hi_ok_s;
  assign in_run   = (state_q == ST_RUN);

  assign det_en    = in_run | (state_q == ST_HOLD);
  assign load_mode = f_mode(opt_byte);
  assign two_level = (mode == `SVD_MODE_IRQRST);
  // one decode per strobe keeps the register map in a single place
  assign wr_level  = reg_wr & f_hit(reg_addr, `SVD_REG_LEVEL);
  assign wr_stat   = reg_wr & f_hit(reg_addr, `SVD_REG_STAT);
  assign rd_cause  = reg_rd & f_hit(reg_addr, `SVD_REG_CAUSE);
  // the power-up hold is not a detector event, so only a rise in run counts
  assign det_reset_rise = in_run & rst_d & ~rst_q;

  // option byte is caught once after reset release; software cannot touch it
  always @* begin
    opt_d = opt_q;
    if ((state_q == ST_LOAD) && opt_valid) begin
      opt_d = opt_byte; // [RQ1]
    end
  end

  // nothing below depends on a stop or clock-gating input, so the
  // detector keeps acting in the low-power state as long as clk runs
  always @* begin
    state_d = state_q;
    rst_d   = rst_q;
    irq_d   = 1'b0;
    case (state_q)
      ST_LOAD: begin
        rst_d = 1'b1;
        if (opt_valid) begin
          if (load_mode == `SVD_MODE_OFF) begin
            state_d = ST_OFF;
            rst_d   = 1'b0;
          end else if (load_mode == `SVD_MODE_IRQ) begin
            state_d = ST_HOLD; // [RQ7]
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_HOLD: begin
        rst_d = 1'b1; // [RQ7]
        if (hi_ok_s) begin
          rst_d   = 1'b0; // [RQ7]
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        case (mode)
          `SVD_MODE_IRQRST: begin
            if (!lo_ok_s) begin
              rst_d = 1'b1; // [RQ5] [RQ3]
            end else if (hi_ok_s) begin
              rst_d = 1'b0; // [RQ5]
            end
            irq_d = hi_fall & ~rst_q; // [RQ5] [RQ3]
          end
          `SVD_MODE_RST: begin
            rst_d = ~hi_ok_s; // [RQ6] [RQ3]
          end
          `SVD_MODE_IRQ: begin
            rst_d = 1'b0;
            irq_d = hi_cross; // [RQ8] [RQ3]
          end
          default: begin
            rst_d = 1'b0;
          end
        endcase
      end
      ST_OFF: begin
        rst_d = 1'b0;
      end
      default: begin
        state_d = ST_LOAD;
        rst_d   = 1'b1;
      end
    endcase
  end

  // flag reads 1 while the supply is below the level in use; in the
  // two-level mode the level-select bit picks which comparator is shown
  always @* begin
    flag_d = 1'b0;
    if (det_en) begin
      if (two_level && lvl_sel_q) begin
        flag_d = ~lo_ok_s; // [RQ9]
      end else begin
        flag_d = ~hi_ok_s; // [RQ9]
      end
    end
  end

  // level register: software writes it, the interrupt forces both bits to 1
  always @* begin
    lvl_sel_d = lvl_sel_q;
    rsi_sel_d = rsi_sel_q;
    if (wr_level) begin
      lvl_sel_d = reg_wdata[`SVD_LEVEL_SEL_BIT];
      rsi_sel_d = reg_wdata[`SVD_LEVEL_MODE_BIT];
    end
    // set wins over a write in the same cycle
    if (irq_d) begin
      lvl_sel_d = 1'b1; // [RQ12]
      rsi_sel_d = 1'b1; // [RQ12]
    end
  end

  // cause flag clears on read; a new detector reset in that cycle wins
  always @* begin
    cause_d = cause_q;
    if (rd_cause) begin
      cause_d = 1'b0;
    end
    if (det_reset_rise) begin
      cause_d = 1'b1; // [RQ10]
    end
  end

  // wrapping count of interrupt events, handy for software polling
  always @* begin
    edge_cnt_d = edge_cnt_q;
    if (wr_stat) begin
      edge_cnt_d = `SVD_EDGE_RST;
    end
    if (irq_d) begin
      edge_cnt_d = edge_cnt_q + `SVD_EDGE_ONE;
    end
  end

  // read data stand only in the cycle after the read strobe
  always @* begin
    rdata_d = `SVD_RDATA_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `SVD_REG_CTRL: begin
          rdata_d[`SVD_CTRL_FLAG_BIT]  = flag_q; // [RQ9]
          rdata_d[`SVD_CTRL_RESET_BIT] = rst_q;
          rdata_d[`SVD_CTRL_EN_BIT]    = det_en;
        end
        `SVD_REG_LEVEL: begin
          rdata_d[`SVD_LEVEL_SEL_BIT]  = lvl_sel_q;
          rdata_d[`SVD_LEVEL_MODE_BIT] = rsi_sel_q;
        end
        `SVD_REG_CAUSE: begin
          rdata_d[`SVD_CAUSE_BIT] = cause_q; // [RQ10]
        end
        `SVD_REG_OPT: begin
          rdata_d = opt_q;
        end
        `SVD_REG_STAT: begin
          rdata_d[`SVD_STAT_HI_BIT] = hi_ok_s;
          rdata_d[`SVD_STAT_LO_BIT] = lo_ok_s;
          rdata_d[`SVD_STAT_EDGE_MSB:`SVD_STAT_EDGE_LSB] = edge_cnt_q;
        end
        default: begin
          rdata_d = `SVD_RDATA_ZERO;
        end
      endcase
    end
  end

  // reset holds the detector reset output high: the chip stays in reset
  // until the option byte is known and, except in the off mode, the supply judged
  // no stop or gating input reaches these flops, so they act in stop
  always @(posedge clk) begin // [RQ4]
    if (rst) begin
      state_q   <= ST_LOAD;
      opt_q     <= `SVD_OPT_RST;
      rst_q     <= 1'b1;
      irq_q     <= 1'b0;
      hi_prev_q <= 1'b0;
      flag_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      opt_q     <= opt_d;
      rst_q     <= rst_d;
      irq_q     <= irq_d;
      hi_prev_q <= hi_ok_s;
      flag_q    <= flag_d;
    end
  end

  // software-visible state; a whole-design reset leaves no cause behind
  always @(posedge clk) begin
    if (rst) begin
      lvl_sel_q  <= `SVD_LEVEL_RST;
      rsi_sel_q  <= `SVD_LEVEL_RST;
      cause_q    <= 1'b0;
      edge_cnt_q <= `SVD_EDGE_RST;
    end else begin
      lvl_sel_q  <= lvl_sel_d;
      rsi_sel_q  <= rsi_sel_d;
      cause_q    <= cause_d;
      edge_cnt_q <= edge_cnt_d;
    end
  end

  // read data register: zero outside the cycle after a read strobe
  always @(posedge clk) begin
    if (rst) begin
      rdata_q <= `SVD_RDATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign opt_addr          = `SVD_OPT_ADDR; // [RQ1]
  assign reg_rdata         = rdata_q;
  assign undervolt_reset   = rst_q; // [RQ3]
  assign undervolt_irq     = irq_q;
  assign supply_level_flag = flag_q;
  assign threshold_sel     = level; // [RQ2]
  assign detector_mode     = mode;
  assign detector_enable   = det_en;

endmodule
`default_nettype wire

// ==== bench/svd_ctrl_props.sv ====
// assertions on the ports of the detector control block
// assumes one clock and a synchronous active-high reset
`default_nettype none
module svd_ctrl_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmp_hi_ok,
  input wire logic        cmp_lo_ok,
  input wire logic [19:0] opt_addr,
  input wire logic        undervolt_reset,
  input wire logic        undervolt_irq,
  input wire logic        supply_level_flag,
  input wire logic [3:0]  threshold_sel,
  input wire logic [1:0]  detector_mode,
  input wire logic        detector_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // four steady samples cover the two sync flops plus the output register
  sequence hi_steady;
    (detector_enable && $stable(cmp_hi_ok))[*4];
  endsequence
  a_opt_addr_fixed: assert property (opt_addr == 20'h000C1)
    else $error("option address wrong");
  a_level_clamped: assert property (threshold_sel <= 4'hA)
    else $error("level code out of range");
  a_reset_follows_hi: assert property (hi_steady ##0 (detector_mode == 2'h3) |-> (undervolt_reset == !cmp_hi_ok))
    else $error("reset does not follow supply");
  a_flag_follows_hi: assert property (hi_steady ##0 (detector_mode == 2'h3) |-> (supply_level_flag == !cmp_hi_ok))
    else $error("flag does not follow supply");
  a_reset_mode_quiet: assert property (detector_mode == 2'h3 |-> !undervolt_irq)
    else $error("irq in reset mode");
  a_off_mode_quiet: assert property (detector_mode == 2'h0 |-> !undervolt_irq && !supply_level_flag)
    else $error("activity while detector off");
  a_low_gives_reset: assert property ((detector_enable && detector_mode == 2'h2 && !cmp_lo_ok)[*4] |-> undervolt_reset)
    else $error("no reset below low level");
  a_irq_on_fall: assert property (undervolt_irq && detector_mode == 2'h2 |-> $past(cmp_hi_ok, 4) && !$past(cmp_hi_ok, 3))
    else $error("irq without falling supply");
  a_irq_on_cross: assert property (undervolt_irq && detector_mode == 2'h1 |-> $past(cmp_hi_ok, 4) != $past(cmp_hi_ok, 3))
    else $error("irq without crossing");
endmodule
bind svd_ctrl svd_ctrl_props svd_ctrl_props_inst (.clk(clk), .rst(rst), .cmp_hi_ok(cmp_hi_ok), .cmp_lo_ok(cmp_lo_ok),
  .opt_addr(opt_addr), .undervolt_reset(undervolt_reset), .undervolt_irq(undervolt_irq),
  .supply_level_flag(supply_level_flag), .threshold_sel(threshold_sel), .detector_mode(detector_mode),
  .detector_enable(detector_enable));
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the detector control block
// assumes the bench plays both the option loader and the register master
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, cmp_hi_ok = 1'b0, cmp_lo_ok = 1'b0;
  logic        opt_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  opt_byte = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, ob;
  logic [31:0] seed = 32'h4C377A82, r;
  wire  [19:0] opt_addr;
  wire  [7:0]  reg_rdata;
  wire  [3:0]  threshold_sel;
  wire  [1:0]  detector_mode;
  wire         undervolt_reset, undervolt_irq, supply_level_flag, detector_enable;
  integer      fail_count = 0, num_checks = 0, irq_n = 0, base, cnt, m;
  svd_ctrl svd_ctrl_inst (.clk(clk), .rst(rst), .cmp_hi_ok(cmp_hi_ok), .cmp_lo_ok(cmp_lo_ok),
    .opt_byte(opt_byte), .opt_valid(opt_valid), .opt_addr(opt_addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .undervolt_reset(undervolt_reset), .undervolt_irq(undervolt_irq), .supply_level_flag(supply_level_flag),
    .threshold_sel(threshold_sel), .detector_mode(detector_mode), .detector_enable(detector_enable));
  always #4 clk = ~clk;
  always @(posedge clk) if (undervolt_irq === 1'b1) irq_n <= irq_n + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // six cycles leave room for the three-edge path plus margin
  task automatic setc(input logic h, input logic l);
    @(posedge clk);
    cmp_hi_ok <= h;
    cmp_lo_ok <= l;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic [7:0] b);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst       <= 1'b0;
    opt_byte  <= b;
    opt_valid <= 1'b1;
    @(posedge clk);
    opt_valid <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  // every mode boots with the supply low, so hold and cause paths are all exercised
  initial begin
    for (m = 0; m < 4; m++) begin
      r  = rnd();
      ob = {2'b00, r[3:0], m[1:0]};
      setc(1'b0, 1'b0);
      boot(ob);
      base = irq_n;
      cnt  = (m == 1) ? 2 : (m == 2);
      chk("mode", m[1:0], detector_mode);
      chk("level", (r[3:0] > 4'hA) ? 4'hA : r[3:0], threshold_sel);
      chk("reset boot", m != 0, undervolt_reset);
      chk("enable", m != 0, detector_enable);
      chk("opt addr", 20'h000C1, opt_addr);
      wr(8'h03, r[15:8]);
      rd(8'h03, ob, "option reg");
      wr(8'h01, r[23:16]);
      rd(8'h01, r[23:16] & 8'h81, "level reg");
      rd({1'b1, r[30:24]}, 8'h00, "unmapped");
      setc(1'b1, 1'b1);
      chk("reset up", 1'b0, undervolt_reset);
      chk("irq up", 0, irq_n - base);
      rd(8'h02, 8'h00, "cause boot");
      setc(1'b0, 1'b1);
      chk("flag", m == 1 || m == 3, supply_level_flag);
      rd(8'h00, {m != 0, 5'h00, m == 3, m == 1 || m == 3}, "ctrl");
      setc(1'b0, 1'b0);
      chk("reset low", m >= 2, undervolt_reset);
      rd(8'h02, m >= 2, "cause");
      rd(8'h02, 8'h00, "cause clear");
      setc(1'b1, 1'b1);
      chk("reset off", 1'b0, undervolt_reset);
      chk("irq count", cnt, irq_n - base);
      rd(8'h01, (cnt != 0) ? 8'h81 : (r[23:16] & 8'h81), "level irq");
      rd(8'h04, {cnt[3:0], 4'h3}, "status");
      wr(8'h04, r[7:0]);
      rd(8'h04, 8'h03, "status clear");
    end
    end_of_test();
  end
endmodule
`default_nettype wire
